// *** inc/sbst_regs.svh ***
// Constants of the scan test port: instruction codes, lengths, ID fields
`ifndef SBST_REGS_SVH
`define SBST_REGS_SVH
`define SBST_IR_LEN        3
`define SBST_ID_LEN        32
`define SBST_BSR_LEN       107
`define SBST_OE_CELL       47
`define SBST_IR_EXTEST     3'h0
`define SBST_IR_IDCODE     3'h1
`define SBST_IR_SAMPLE_Z   3'h2
`define SBST_IR_PRELOAD    3'h4
`define SBST_IR_BYPASS     3'h7
`define SBST_IR_CAPTURE    3'h1
`define SBST_ID_VER_HI     31
`define SBST_ID_VER_LO     29
`define SBST_ID_PART_HI    28
`define SBST_ID_PART_LO    12
`define SBST_ID_MAKER_HI   11
`define SBST_ID_MAKER_LO   1
`define SBST_ID_PRESENT    0
`define SBST_TCK_MIN_NS    50
`define SBST_CLK_NS        40
`endif

// *** inc/sbst_pkg.sv ***
// Types of the scan test port
package sbst_pkg;
	typedef enum logic [3:0] {
		TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h2, CAP_DR = 4'h3,
		SH_DR = 4'h4, EX1_DR = 4'h5, PA_DR = 4'h6, EX2_DR = 4'h7,
		UPD_DR = 4'h8, SEL_IR = 4'h9, CAP_IR = 4'ha, SH_IR = 4'hb,
		EX1_IR = 4'hc, PA_IR = 4'hd, EX2_IR = 4'he, UPD_IR = 4'hf
	} sbst_state_t;
endpackage

// *** verilog/sbst_sync.sv ***
// Three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module sbst_sync (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic arst_n_in,
	// Pin and filtered level
	input  wire logic pin_in,
	output logic      level_out
);
	logic s1_q, s2_q, s3_q;

	// Shift chain; first stage only feeds the second
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s1_q <= 1'h0;
			s2_q <= 1'h0;
			s3_q <= 1'h0;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Level changes only when stages two and three agree
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			level_out <= 1'h0;
		end else if (s2_q == s3_q) begin
			level_out <= s3_q;
		end
	end
endmodule

// *** verilog/sbst_tap.sv ***
// Boundary scan test access port of the memory device
//
// How it works
// - IR 3, bypass 1, ID 32, boundary 107
// - Code 000 captures ring, drives preload out
// - Code 001 selects fixed ID register
// - Code 010 samples, boundary path, outputs high-Z
// - Code 100 samples ring onto boundary path
// - Code 111 selects single-bit bypass
// - ID fields: version, part type, maker
// - ID bit 0 always one
// - TMS and TDI sampled on rising TCK
// - TDO updated on falling TCK
// - ID instruction after reset and Test-Logic-Reset
// - Cell 47 enables output bus under EXTEST
// - New instruction applies only at Update-IR
// - High-Z sample holds until next Update-IR or Test-Logic-Reset
`timescale 1ns/1ps
`include "sbst_regs.svh"
module sbst_tap #(
	parameter int                    BSR_LEN     = `SBST_BSR_LEN,
	parameter logic [2:0]            VERSION     = 3'h0,     // Arbitrary value
	parameter logic [16:0]           PART_TYPE   = 17'h00001, // Arbitrary value
	parameter logic [10:0]           MAKER_CODE  = 11'h001    // Arbitrary value
) (
	// Clock and reset
	input  wire logic               CLK_IN,
	input  wire logic               ARST_N_IN,
	// Test pins
	input  wire logic               TCK_IN,
	input  wire logic               TMS_IN,
	input  wire logic               TDI_IN,
	output logic                    TDO_OUT,
	output logic                    TDO_OE_OUT,
	// Boundary ring
	input  wire logic [BSR_LEN-1:0] RING_IN,
	output logic [BSR_LEN-1:0]      RING_OUT,
	output logic                    EXTEST_OUT,
	output logic                    OUT_BUS_EN_OUT,
	// Status
	output logic [2:0]              IR_OUT
);
	// Number of system clocks in the shortest allowed test clock period
	localparam int TCK_CYC = (`SBST_TCK_MIN_NS + `SBST_CLK_NS - 1) / `SBST_CLK_NS;

	logic                    tck_l, tms_l, tdi_l;
	logic                    tck_d1_q;
	logic                    rise, fall;
	sbst_pkg::sbst_state_t   st_q, st_d;
	logic [2:0]              ir_sh_q, ir_q;
	logic                    byp_q;
	logic [`SBST_ID_LEN-1:0] id_q;
	logic [BSR_LEN-1:0]      bsr_q, upd_q;
	logic                    tdo_d;
	logic [31:0]             id_const;

	// Synchronise the three test inputs into the system clock
	sbst_sync u_tck (.clk_in(CLK_IN), .arst_n_in(ARST_N_IN), .pin_in(TCK_IN), .level_out(tck_l));
	sbst_sync u_tms (.clk_in(CLK_IN), .arst_n_in(ARST_N_IN), .pin_in(TMS_IN), .level_out(tms_l));
	sbst_sync u_tdi (.clk_in(CLK_IN), .arst_n_in(ARST_N_IN), .pin_in(TDI_IN), .level_out(tdi_l));

	// Edge detect on the filtered test clock
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			tck_d1_q <= 1'h0;
		end else begin
			tck_d1_q <= tck_l;
		end
	end
	// TMS/TDI pass the same filter, so their levels are aligned to the edge
	assign rise = tck_l & ~tck_d1_q;
	assign fall = ~tck_l & tck_d1_q;

	// Fixed identification word
	assign id_const = {VERSION, PART_TYPE, MAKER_CODE, 1'h1};

	// Controller next-state logic
	always_comb begin
		st_d = st_q;
		case (st_q)
			sbst_pkg::TLR:    st_d = tms_l ? sbst_pkg::TLR    : sbst_pkg::RTI;
			sbst_pkg::RTI:    st_d = tms_l ? sbst_pkg::SEL_DR : sbst_pkg::RTI;
			sbst_pkg::SEL_DR: st_d = tms_l ? sbst_pkg::SEL_IR : sbst_pkg::CAP_DR;
			sbst_pkg::CAP_DR: st_d = tms_l ? sbst_pkg::EX1_DR : sbst_pkg::SH_DR;
			sbst_pkg::SH_DR:  st_d = tms_l ? sbst_pkg::EX1_DR : sbst_pkg::SH_DR;
			sbst_pkg::EX1_DR: st_d = tms_l ? sbst_pkg::UPD_DR : sbst_pkg::PA_DR;
			sbst_pkg::PA_DR:  st_d = tms_l ? sbst_pkg::EX2_DR : sbst_pkg::PA_DR;
			sbst_pkg::EX2_DR: st_d = tms_l ? sbst_pkg::UPD_DR : sbst_pkg::SH_DR;
			sbst_pkg::UPD_DR: st_d = tms_l ? sbst_pkg::SEL_DR : sbst_pkg::RTI;
			sbst_pkg::SEL_IR: st_d = tms_l ? sbst_pkg::TLR    : sbst_pkg::CAP_IR;
			sbst_pkg::CAP_IR: st_d = tms_l ? sbst_pkg::EX1_IR : sbst_pkg::SH_IR;
			sbst_pkg::SH_IR:  st_d = tms_l ? sbst_pkg::EX1_IR : sbst_pkg::SH_IR;
			sbst_pkg::EX1_IR: st_d = tms_l ? sbst_pkg::UPD_IR : sbst_pkg::PA_IR;
			sbst_pkg::PA_IR:  st_d = tms_l ? sbst_pkg::EX2_IR : sbst_pkg::PA_IR;
			sbst_pkg::EX2_IR: st_d = tms_l ? sbst_pkg::UPD_IR : sbst_pkg::SH_IR;
			sbst_pkg::UPD_IR: st_d = tms_l ? sbst_pkg::SEL_DR : sbst_pkg::RTI;
			default:          st_d = sbst_pkg::TLR;
		endcase
	end

	// Controller state, stepped on each test clock rise
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			st_q <= sbst_pkg::TLR;
		end else if (rise) begin
			st_q <= st_d;
		end
	end

	// Instruction shift register; capture loads the fixed 01 pattern
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			ir_sh_q <= `SBST_IR_CAPTURE;
		end else if (rise) begin
			if (st_q == sbst_pkg::CAP_IR) begin
				ir_sh_q <= `SBST_IR_CAPTURE;
			end else if (st_q == sbst_pkg::SH_IR) begin
				ir_sh_q <= {tdi_l, ir_sh_q[2:1]};
			end
		end
	end

	// Active instruction; reserved codes are the controller's to avoid
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			ir_q <= `SBST_IR_IDCODE;
		end else if (rise) begin
			if (st_q == sbst_pkg::TLR) begin
				ir_q <= `SBST_IR_IDCODE;
			end else if (st_q == sbst_pkg::UPD_IR) begin
				ir_q <= ir_sh_q;
			end
		end
	end

	// Bypass cell
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			byp_q <= 1'h0;
		end else if (rise) begin
			if (st_q == sbst_pkg::CAP_DR) begin
				byp_q <= 1'h0;
			end else if (st_q == sbst_pkg::SH_DR) begin
				byp_q <= tdi_l;
			end
		end
	end

	// Identification register, reloaded from the fixed word on capture
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			id_q <= '0;
		end else if (rise && ir_q == `SBST_IR_IDCODE) begin
			if (st_q == sbst_pkg::CAP_DR) begin
				id_q <= id_const;
			end else if (st_q == sbst_pkg::SH_DR) begin
				id_q <= {tdi_l, id_q[`SBST_ID_LEN-1:1]};
			end
		end
	end

	// Boundary chain; TDI enters at the top, LSB leaves on TDO
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			bsr_q <= '0;
		end else if (rise && (ir_q == `SBST_IR_EXTEST || ir_q == `SBST_IR_SAMPLE_Z ||
				ir_q == `SBST_IR_PRELOAD)) begin
			if (st_q == sbst_pkg::CAP_DR) begin
				bsr_q <= RING_IN;
			end else if (st_q == sbst_pkg::SH_DR) begin
				bsr_q <= {tdi_l, bsr_q[BSR_LEN-1:1]};
			end
		end
	end

	// Preload latches; cleared at reset so cell 47 starts low for EXTEST
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			upd_q <= '0;
		end else if (rise) begin
			if (st_q == sbst_pkg::TLR) begin
				upd_q <= '0;
			end else if (st_q == sbst_pkg::UPD_DR && (ir_q == `SBST_IR_EXTEST ||
					ir_q == `SBST_IR_PRELOAD || ir_q == `SBST_IR_SAMPLE_Z)) begin
				upd_q <= bsr_q;
			end
		end
	end

	// Serial output mux by controller phase and instruction
	always_comb begin
		tdo_d = 1'h0;
		if (st_q == sbst_pkg::SH_IR) begin
			tdo_d = ir_sh_q[0];
		end else if (st_q == sbst_pkg::SH_DR) begin
			case (ir_q)
				`SBST_IR_IDCODE:   tdo_d = id_q[0];
				`SBST_IR_EXTEST,
				`SBST_IR_SAMPLE_Z,
				`SBST_IR_PRELOAD:  tdo_d = bsr_q[0];
				default:           tdo_d = byp_q;
			endcase
		end
	end

	// TDO launched on the falling test clock; driven only while shifting
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			TDO_OUT    <= 1'h0;
			TDO_OE_OUT <= 1'h0;
		end else if (fall) begin
			TDO_OUT    <= tdo_d;
			TDO_OE_OUT <= (st_q == sbst_pkg::SH_IR) || (st_q == sbst_pkg::SH_DR);
		end
	end

	// Pin controls; high-Z sample forces the bus enable low until replaced
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			RING_OUT       <= '0;
			EXTEST_OUT     <= 1'h0;
			OUT_BUS_EN_OUT <= 1'h1;
			IR_OUT         <= `SBST_IR_IDCODE;
		end else begin
			RING_OUT   <= upd_q;
			EXTEST_OUT <= (ir_q == `SBST_IR_EXTEST);
			IR_OUT     <= ir_q;
			if (ir_q == `SBST_IR_SAMPLE_Z) begin
				OUT_BUS_EN_OUT <= 1'h0;
			end else if (ir_q == `SBST_IR_EXTEST) begin
				OUT_BUS_EN_OUT <= upd_q[`SBST_OE_CELL];
			end else begin
				OUT_BUS_EN_OUT <= 1'h1;
			end
		end
	end

	// TCK_CYC documents the fastest test clock the sampler must keep up with; unused_ok only checks it is above 0
	logic unused_ok;
	assign unused_ok = (TCK_CYC > 0);
endmodule

// *** verification/sbst_tap_assertions.sv ***
// Checker of the scan port pins
`timescale 1ns/1ps
module sbst_tap_chk #(
	parameter int BSR_LEN = 107
) (
	input wire logic               CLK_IN,
	input wire logic               ARST_N_IN,
	input wire logic               TCK_IN,
	input wire logic               TDO_OUT,
	input wire logic               TDO_OE_OUT,
	input wire logic [BSR_LEN-1:0] RING_OUT,
	input wire logic               EXTEST_OUT,
	input wire logic               OUT_BUS_EN_OUT,
	input wire logic [2:0]         IR_OUT
);
	logic       tck_q;
	logic [3:0] fall_cnt_q;
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!ARST_N_IN);
	// Cycles since pin fall; saturates so a stalled clock flags late launches
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			tck_q      <= 1'b0;
			fall_cnt_q <= 4'hf;
		end else begin
			tck_q      <= TCK_IN;
			fall_cnt_q <= (tck_q & !TCK_IN) ? 4'h0 : fall_cnt_q + {3'h0, fall_cnt_q != 4'hf};
		end
	end
	a_reset_id: assert property (!$past(ARST_N_IN) |-> IR_OUT == 3'h1 && OUT_BUS_EN_OUT)
		else $error("bad state after reset");
	a_extest_flag: assert property ($stable(IR_OUT) |-> EXTEST_OUT == (IR_OUT == 3'h0))
		else $error("bad extest flag");
	a_bus_z_hold: assert property (IR_OUT == 3'h2 && $stable(IR_OUT) |-> !OUT_BUS_EN_OUT)
		else $error("bus driven in high-z sample");
	a_bus_cell_ext: assert property (IR_OUT == 3'h0 && $stable(IR_OUT) && $stable(RING_OUT)
		|-> OUT_BUS_EN_OUT == RING_OUT[47])
		else $error("bus enable not from cell");
	a_bus_en_other: assert property (IR_OUT inside {3'h1, 3'h4, 3'h7} && $stable(IR_OUT)
		|-> OUT_BUS_EN_OUT)
		else $error("memory outputs disturbed");
	a_ir_not_shift: assert property ($changed(IR_OUT) |-> !TDO_OE_OUT && !$past(TDO_OE_OUT))
		else $error("instruction changed in shift");
	a_ring_upd_only: assert property ($changed(RING_OUT) |-> !TDO_OE_OUT)
		else $error("preload changed in shift");
	a_tdo_on_fall: assert property ($changed(TDO_OUT) |-> fall_cnt_q inside {[3:7]})
		else $error("data out not after fall");
	a_oe_on_fall: assert property ($changed(TDO_OE_OUT) |-> fall_cnt_q inside {[3:7]})
		else $error("enable out not after fall");
	c_extest_on: cover property (EXTEST_OUT && OUT_BUS_EN_OUT);
	c_samplez: cover property (IR_OUT == 3'h2 && !OUT_BUS_EN_OUT);
	c_shift: cover property ($rose(TDO_OE_OUT));
endmodule
bind sbst_tap sbst_tap_chk #(.BSR_LEN(BSR_LEN)) u_chk (.CLK_IN(CLK_IN), .ARST_N_IN(ARST_N_IN),
	.TCK_IN(TCK_IN), .TDO_OUT(TDO_OUT), .TDO_OE_OUT(TDO_OE_OUT), .RING_OUT(RING_OUT),
	.EXTEST_OUT(EXTEST_OUT), .OUT_BUS_EN_OUT(OUT_BUS_EN_OUT), .IR_OUT(IR_OUT));

// *** verification/sbst_jtag_host.sv ***
// Board-side scan controller model driving the test pins
`timescale 1ns/1ps
module sbst_jtag_host (
	// Clock for pin pacing
	input  wire logic clk_in,
	// Test pins
	input  wire logic tdo_in,
	output logic      tck_out,
	output logic      tms_out,
	output logic      tdi_out
);
	// Clock stands low between frames
	initial begin
		tck_out = 1'b0;
		tms_out = 1'b1;
		tdi_out = 1'b0;
	end
	// One 320 ns cycle; data out read late since it trails the fall
	task automatic step(input logic tms, input logic tdi, output logic tdo);
		tms_out = tms;
		tdi_out = tdi;
		repeat (4) @(posedge clk_in);
		#1 tck_out = 1'b1;
		repeat (4) @(posedge clk_in);
		tdo = tdo_in;
		#1 tck_out = 1'b0;
	endtask
	// Walk a TMS sequence, LSB first; idle data line toggles
	task automatic nav(input logic [7:0] seq, input int n);
		logic d;
		for (int i = 0; i < n; i++) begin
			step(seq[i], ~tdi_out, d);
		end
		// Let the last rise reach the registered pins before anyone looks
		repeat (3) @(posedge clk_in);
		#1;
	endtask
	// Only defined codes are ever sent
	task automatic ir_load(input logic [2:0] code, output logic [2:0] cap);
		nav(8'h03, 4);
		for (int i = 0; i < 3; i++) begin
			step(i == 2, code[i], cap[i]);
		end
		nav(8'h01, 2);
	endtask
	// Data scan of n bits from idle back to idle
	task automatic dr_scan(input int n, input logic [106:0] din, output logic [106:0] dout);
		nav(8'h01, 3);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], dout[i]);
		end
		nav(8'h01, 2);
	endtask
endmodule

// *** verification/sbst_tap_tb.sv ***
// Self-checking bench of the scan test port
`timescale 1ns/1ps
module sbst_tap_tb;
	localparam logic [2:0]   VER  = 3'h5;     // Arbitrary value
	localparam logic [16:0]  PART = 17'h0a5a5; // Arbitrary value
	localparam logic [10:0]  MAKR = 11'h2c3;  // Arbitrary value
	localparam logic [106:0] P1   = 107'h5a96_c3e1_0f2d_3487_3c5a_96e1; // Cell 47 low
	localparam logic [106:0] P2   = ~P1 | (107'h1 << 47);
	logic         clk, arst_n, tck, tms, tdi, tdo, tdo_oe, extest, bus_en;
	logic [106:0] ring_in, ring_out, v;
	logic [2:0]   ir, c;
	int           failures = 0, tests_run = 0, cycles = 0;
	sbst_tap #(.VERSION(VER), .PART_TYPE(PART), .MAKER_CODE(MAKR)) uut (.CLK_IN(clk),
		.ARST_N_IN(arst_n), .TCK_IN(tck), .TMS_IN(tms), .TDI_IN(tdi), .TDO_OUT(tdo),
		.TDO_OE_OUT(tdo_oe), .RING_IN(ring_in), .RING_OUT(ring_out), .EXTEST_OUT(extest),
		.OUT_BUS_EN_OUT(bus_en), .IR_OUT(ir));
	sbst_jtag_host u_host (.clk_in(clk), .tdo_in(tdo), .tck_out(tck), .tms_out(tms),
		.tdi_out(tdi));
	task automatic chk(input logic [106:0] got, input logic [106:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %0t %s", $time, m);
		end
	endtask
	task automatic final_report();
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Clock, 40 ns period
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Hang guard, well above the run's few thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			final_report();
		end
	end
	// Main sequence
	initial begin
		arst_n = 1'b0;
		ring_in = P1;
		repeat (8) @(posedge clk);
		#1 arst_n = 1'b1;
		repeat (8) @(posedge clk);
		#1 chk(ir, 3'h1, "ir after reset");
		u_host.nav(8'h00, 1);
		u_host.dr_scan(33, 107'h1, v);
		chk(v[32:0], {1'b1, VER, PART, MAKR, 1'b1}, "id code");
		$display("test id done");
		u_host.ir_load(3'h7, c);
		chk(c, 3'h1, "ir capture");
		chk(ir, 3'h7, "bypass ir");
		u_host.dr_scan(2, 107'h3, v);
		chk(v[1:0], 2'b10, "bypass path");
		$display("test bypass done");
		u_host.ir_load(3'h4, c);
		u_host.dr_scan(107, P2, v);
		chk(v, P1, "sample capture");
		chk({bus_en, ring_out}, {1'b1, P2}, "preload");
		$display("test sample done");
		ring_in = ~P1;
		u_host.ir_load(3'h0, c);
		chk({extest, bus_en, ring_out}, {2'b11, P2}, "extest drive");
		u_host.dr_scan(107, P1, v);
		chk(v, ~P1, "extest capture");
		chk(bus_en, 1'b0, "cell low");
		$display("test extest done");
		u_host.ir_load(3'h2, c);
		u_host.dr_scan(107, P2, v);
		chk(v, ~P1, "high-z capture");
		chk({extest, bus_en}, 2'b00, "high-z held");
		u_host.nav(8'h1f, 6);
		chk({ir, bus_en}, 4'h3, "reset to id");
		$display("test high-z done");
		final_report();
	end
endmodule
